// >>> core/adm_shreg.v
`default_nettype none

`include "adm_consts.vh"

// ----------------------------------------
// output shifter with chain refill
// ----------------------------------------
// in short mode the word sits in the top 24 bits and chain bits enter at
// bit 8, so the next device's msb follows our lsb with no gap
module adm_shreg (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        clear,
  input  wire        load,
  input  wire [31:0] loadWord,
  input  wire        shift,
  input  wire        serialIn,
  input  wire        shortMode,
  output wire        msb
);

  reg [31:0] sh_reg;
  reg [31:0] sh_next;

  always @*
  begin
    sh_next = {sh_reg[30:0], serialIn};
    if (shortMode)
      sh_next[`ADM_SHORT_POS] = serialIn;
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sh_reg <= 32'h0;
    else if (clear)
      sh_reg <= 32'h0;
    else if (load)
      sh_reg <= loadWord;
    else if (shift)
      sh_reg <= sh_next;
  end

  assign msb = sh_reg[`ADM_WORD_BITS-1];

endmodule

`default_nettype wire

// >>> core/adm_sync.v
`default_nettype none

// ----------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------
module adm_sync #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage_reg;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_reg <= RESET_VAL;
      syncOut   <= RESET_VAL;
    end
    else
    begin
      stage_reg <= asyncIn;
      syncOut   <= stage_reg;
    end
  end

endmodule

`default_nettype wire

// >>> core/adm_top.v
`default_nettype none

`include "adm_consts.vh"

module adm_top (
  input  wire        mclk,
  input  wire        resetn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // configuration straps
  input  wire        highResolutionSelect,
  input  wire [1:0]  oversamplingRatioSelect,
  input  wire [1:0]  filterSelect,
  input  wire        interfaceFormatSelect,
  input  wire        frameSyncRole,
  // control pins
  input  wire        startPin,
  input  wire        resetPowerdownN,
  // filter output, mclk domain
  input  wire [23:0] convData,
  // serial link
  input  wire        sclk,
  input  wire        chipSelectN,
  input  wire        serialDataIn,
  input  wire        chainSerialInput,
  input  wire        frameSyncIn,
  output reg         frameSyncOut,
  output reg         frameSyncOe,
  output reg         serialDataOut,
  output reg         serialDataOe,
  output reg         sampleReadyN
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [6:0] strapS;
  wire [5:0] linkS;

  adm_sync #(.WIDTH(7)) u_strap (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn ({highResolutionSelect, oversamplingRatioSelect,
               filterSelect, interfaceFormatSelect, frameSyncRole}),
    .syncOut (strapS)
  );

  // serial data in feeds no logic here: the register port is wishbone
  // pins reset to their idle levels, so no false select edge follows reset
  adm_sync #(.WIDTH(6), .RESET_VAL(`ADM_LINK_IDLE)) u_link (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn ({sclk, chipSelectN, chainSerialInput, frameSyncIn,
               startPin, resetPowerdownN}),
    .syncOut (linkS)
  );

  wire sclkS  = linkS[5];
  wire csNS   = linkS[4];
  wire chainS = linkS[3];
  wire fsInS  = linkS[2];
  wire startS = linkS[1];
  wire rpdNS  = linkS[0];

  // ----------------------------------------
  // settings register
  // ----------------------------------------
  wire [7:0] settings;

  assign settings[`ADM_SET_RSVD] = 1'b0;
  assign settings[`ADM_SET_HR] = strapS[6];
  assign settings[`ADM_SET_OSR_HI:`ADM_SET_OSR_LO] = strapS[5:4];
  assign settings[`ADM_SET_FLT_HI:`ADM_SET_FLT_LO] = strapS[3:2];
  assign settings[`ADM_SET_FORMAT] = strapS[1];
  assign settings[`ADM_SET_ROLE] = strapS[0];

  wire isFrameSync = settings[`ADM_SET_FORMAT];
  wire isSpi       = ~isFrameSync;
  wire isMaster    = isFrameSync & settings[`ADM_SET_ROLE];
  wire [1:0] oversampling_ratio_select   = settings[`ADM_SET_OSR_HI:`ADM_SET_OSR_LO];
  wire [1:0] flt   = settings[`ADM_SET_FLT_HI:`ADM_SET_FLT_LO];

  // ----------------------------------------
  // ratio decode
  // ----------------------------------------
  reg [11:0] ratio;

  // the reserved filter code decodes as wideband; it has no rate of its own
  always @*
  begin
    if (flt == `ADM_FLT_LOWLAT)
    begin
      case (oversampling_ratio_select)
        2'h0:    ratio = `ADM_LL_R0;
        2'h1:    ratio = `ADM_LL_R1;
        2'h2:    ratio = `ADM_LL_R2;
        2'h3:    ratio = `ADM_LL_R3;
        default: ratio = `ADM_LL_R0;
      endcase
    end
    else
    begin
      case (oversampling_ratio_select)
        2'h0:    ratio = `ADM_WB_R0;
        2'h1:    ratio = `ADM_WB_R1;
        2'h2:    ratio = `ADM_WB_R2;
        2'h3:    ratio = `ADM_WB_R3;
        default: ratio = `ADM_WB_R0;
      endcase
    end
  end

  wire [`ADM_CNT_W-1:0] period =
    {4'h0, ratio} << `ADM_MOD_SHIFT;
  wire [`ADM_CNT_W-1:0] latency = period << `ADM_LAT_SHIFT;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  reg        ctlSwd_reg;
  wire       wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [5:0] wbIdx  = wb_adr_i[7:2];
  reg [31:0] rdData;

  always @*
  begin
    case (wbIdx)
      `ADM_IDX_SETTINGS: rdData = {24'h0, settings};
      `ADM_IDX_CONTROL:  rdData = {31'h0, ctlSwd_reg};
      `ADM_IDX_RATIO:    rdData = {20'h0, ratio};
      default:           rdData = 32'h0;
    endcase
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i)
        wb_dat_o <= rdData;
    end
  end

  // writes to the settings index fall through and change nothing
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ctlSwd_reg <= `ADM_CTL_RESET;
    else if (!rpdNS)
      ctlSwd_reg <= `ADM_CTL_RESET;
    else if (wbReq && wb_we_i && wb_sel_i[0] &&
             wbIdx == `ADM_IDX_CONTROL)
      ctlSwd_reg <= wb_dat_i[`ADM_CTL_SWD];
  end

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  reg                  startPrev_reg;
  reg [`ADM_CNT_W-1:0] convCnt_reg;
  reg [23:0]           hold_reg;
  reg [3:0]            drdyCnt_reg;
  wire startRise = startS & ~startPrev_reg;
  wire newSample = rpdNS & ~startRise & (convCnt_reg == 16'h0);

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      startPrev_reg <= 1'b0;
      convCnt_reg   <= 16'h0;
      hold_reg      <= 24'h0;
    end
    else
    begin
      startPrev_reg <= startS;
      if (!rpdNS || startRise)
        convCnt_reg <= latency;
      else if (newSample)
        convCnt_reg <= period - 16'h1;
      else
        convCnt_reg <= convCnt_reg - 16'h1;
      if (newSample)
        hold_reg <= convData;
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      drdyCnt_reg  <= 4'h0;
      sampleReadyN <= 1'b1;
    end
    else
    begin
      if (newSample)
        drdyCnt_reg <= `ADM_SAMPLE_READY_STROBE_CYC;
      else if (drdyCnt_reg != 4'h0)
        drdyCnt_reg <= drdyCnt_reg - 4'h1;
      sampleReadyN <= ~(newSample | (drdyCnt_reg > 4'h1));
    end
  end

  // ----------------------------------------
  // serial framing
  // ----------------------------------------
  reg  sclkPrev_reg;
  reg  csPrev_reg;
  reg  fsPrev_reg;
  reg  chainBit_reg;
  wire sclkRise = sclkS & ~sclkPrev_reg;
  wire sclkFall = ~sclkS & sclkPrev_reg;
  wire csFall   = ~csNS & csPrev_reg;
  wire fsRise   = fsInS & ~fsPrev_reg;
  wire serClr   = isMaster & ~rpdNS;

  // frame start per mode; select is ignored outside spi
  wire frameLoad = isSpi ? csFall :
                   (isMaster ? newSample : fsRise);
  wire shiftEn = sclkFall & (isFrameSync | ~csNS);
  // a master never chains, so its chain input is ignored
  wire chainIn = isMaster ? 1'b0 : chainBit_reg;
  wire [31:0] word = {hold_reg, settings};
  wire shMsb;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclkPrev_reg <= 1'b0;
      csPrev_reg   <= 1'b1;
      fsPrev_reg   <= 1'b0;
      chainBit_reg <= 1'b0;
    end
    else
    begin
      sclkPrev_reg <= sclkS;
      csPrev_reg   <= csNS;
      fsPrev_reg   <= fsInS;
      if (sclkRise)
        chainBit_reg <= chainS;
    end
  end

  adm_shreg u_sh (
    .mclk      (mclk),
    .resetn    (resetn),
    .clear     (serClr),
    .load      (frameLoad),
    .loadWord  (word),
    .shift     (shiftEn),
    .serialIn  (chainIn),
    .shortMode (ctlSwd_reg),
    .msb       (shMsb)
  );

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
      frameSyncOut  <= 1'b0;
      frameSyncOe   <= 1'b0;
    end
    else
    begin
      serialDataOut <= shMsb;
      serialDataOe  <= isFrameSync | ~csNS;
      frameSyncOe   <= isMaster;
      if (serClr)
        frameSyncOut <= 1'b0;
      else if (isMaster && newSample)
        frameSyncOut <= 1'b1;
      else if (sclkFall)
        frameSyncOut <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> dv/adm_host_model.sv
`default_nettype none

module adm_host_model (
  output logic      sclk,
  output logic      chipSelectN,
  output logic      chainSerialInput,
  output logic      frameSyncIn,
  input wire logic  serialDataOut,
  input wire logic  serialDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // host reader and chain neighbour
  // ----------------------------------------
  initial
  begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    chainSerialInput = 1'b0;
    frameSyncIn = 1'b0;
  end
  // sclk stands still between frames; a bit is read just before the fall
  task automatic read_frame(input int n, input logic [31:0] nbr,
                            input logic chained, input logic fs,
                            output logic [63:0] got);
    int i;
    got = 64'h0;
    #13;
    // select is held at ground for the whole frame in every mode, frame-sync as well as spi
    chipSelectN = 1'b0;
    frameSyncIn = fs;
    chainSerialInput = chained & nbr[31];
    #400;
    frameSyncIn = 1'b0;
    for (i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      #160;
      got = {got[62:0], serialDataOe ? serialDataOut : 1'bz};
      sclk = 1'b0;
      nbr = {nbr[30:0], 1'b0};
      chainSerialInput = chained & nbr[31];
      #160;
    end
    chipSelectN = 1'b1;
    // released neighbour line shows no stale bit
    chainSerialInput = chained & ~chainSerialInput;
  endtask
endmodule

`default_nettype wire

// >>> dv/adm_top_bench.sv
`default_nettype none

module adm_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        startPin, resetPowerdownN, sampleReadyN;
  logic        sclk, chipSelectN, chainSerialInput, frameSyncIn;
  logic        serialDataOut, serialDataOe;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [6:0]  straps;
  logic [23:0] convData;
  int          fail_count, n_compared;
  localparam logic [31:0] NBR = 32'h9d4e_7b21;
  adm_top u_adm_top (
    .mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .highResolutionSelect(straps[6]),
    .oversamplingRatioSelect(straps[5:4]), .filterSelect(straps[3:2]),
    .interfaceFormatSelect(straps[1]), .frameSyncRole(straps[0]),
    .startPin, .resetPowerdownN, .convData, .sclk, .chipSelectN,
    .serialDataIn(1'b0), .chainSerialInput, .frameSyncIn,
    .frameSyncOut(), .frameSyncOe(), .serialDataOut, .serialDataOe,
    .sampleReadyN);
  adm_host_model u_adm_host_model (
    .sclk, .chipSelectN, .chainSerialInput, .frameSyncIn, .serialDataOut,
    .serialDataOe);
  always #20 mclk = ~mclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, wd};
    do
    begin
      @(posedge mclk);
      k++;
      if (k == 50)
      begin
        fail_count++;
        summarize();
      end
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // counts edges until sampleReadyN falls
  task automatic wait_ready(output int n);
    logic prev;
    n = 0;
    prev = 1'b0;
    while (!(prev === 1'b1 && sampleReadyN === 1'b0))
    begin
      prev = sampleReadyN;
      @(posedge mclk);
      n++;
      if (n == 10000)
      begin
        fail_count++;
        summarize();
      end
    end
  endtask
  function automatic logic [31:0] ratio(input logic [1:0] f, o);
    if (f == 2'h2)
      return 32'h20 << (2 * o);
    return 32'h20 << o;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    logic [31:0] rd;
    for (int i = 0; i < 128; i++)
    begin
      @(posedge mclk);
      straps <= i[6:0];
      repeat (8) @(posedge mclk);
      wb_xfer(1'b0, 8'h1c, 32'h0, rd);
      check(rd, {25'h0, i[6:0]});
      wb_xfer(1'b0, 8'h24, 32'h0, rd);
      check(rd, ratio(i[3:2], i[5:4]));
    end
    wb_xfer(1'b1, 8'h1c, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 8'h1c, 32'h0, rd);
    check(rd, 32'h7f);
    wb_xfer(1'b0, 8'h3c, 32'h0, rd);
    check(rd, 32'h0);
    // low-latency ratio 512: a whole frame fits between two ready pulses
    straps <= 7'h68;
    repeat (8) @(posedge mclk);
  endtask
  task automatic test_frames;
    logic [31:0] rd;
    logic [63:0] got;
    int n;
    wait_ready(n);
    u_adm_host_model.read_frame(64, NBR, 1'b1, 1'b0, got);
    check(got, {convData, 8'h68, NBR});
    repeat (8) @(posedge mclk);
    check(serialDataOe, 1'b0);
    wb_xfer(1'b1, 8'h20, 32'h1, rd);
    wait_ready(n);
    u_adm_host_model.read_frame(56, NBR, 1'b1, 1'b0, got);
    check(got, {8'h0, convData, NBR});
    wait_ready(n);
    u_adm_host_model.read_frame(32, NBR, 1'b0, 1'b0, got);
    check(got, {32'h0, convData, 8'h00});
    @(posedge mclk);
    straps <= 7'h6a;
    wait_ready(n);
    u_adm_host_model.read_frame(56, NBR, 1'b1, 1'b1, got);
    check(got, {8'h0, convData, NBR});
  endtask
  task automatic test_sync;
    logic [31:0] rd;
    int n1, n2, n3;
    @(posedge mclk);
    straps <= 7'h40;
    // line up with a ready pulse so no free-running one lands mid-count
    wait_ready(n1);
    startPin <= 1'b1;
    wait_ready(n1);
    startPin <= 1'b0;
    repeat (40) @(posedge mclk);
    startPin <= 1'b1;
    wait_ready(n2);
    startPin <= 1'b0;
    check(n2, n1);
    check(n1 >= 256 && n1 <= 266, 1);
    wb_xfer(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h1);
    repeat (8) @(posedge mclk);
    resetPowerdownN <= 1'b0;
    repeat (10) @(posedge mclk);
    wb_xfer(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    resetPowerdownN <= 1'b1;
    wait_ready(n3);
    check(n3 >= 256 && n3 <= 266, 1);
  endtask
  initial
  begin
    {mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, startPin} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    wb_sel_i = 4'hf;
    straps = 7'h40;
    resetPowerdownN = 1'b1;
    convData = 24'hc3a5_1e;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    test_regs();
    test_frames();
    test_sync();
    summarize();
  end
endmodule

`default_nettype wire

// >>> dv/adm_top_chk.sv
`default_nettype none

module adm_top_chk (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        highResolutionSelect,
  input wire logic [1:0]  oversamplingRatioSelect,
  input wire logic [1:0]  filterSelect,
  input wire logic        interfaceFormatSelect,
  input wire logic        frameSyncRole,
  input wire logic        resetPowerdownN,
  input wire logic        chipSelectN,
  input wire logic        frameSyncOe,
  input wire logic        frameSyncOut,
  input wire logic        serialDataOe,
  input wire logic        sampleReadyN
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // strap quiet counter
  // ----------------------------------------
  // pins pass two sync flops, so readback is judged only once they settled
  logic [6:0] straps;
  logic [6:0] strapPrev_reg;
  logic [2:0] quietCnt_reg;
  logic       rdSet;
  assign straps = {highResolutionSelect, oversamplingRatioSelect,
                   filterSelect, interfaceFormatSelect, frameSyncRole};
  assign rdSet = wb_ack_o && !wb_we_i && wb_adr_i == 8'h1c
                 && quietCnt_reg == 3'h7;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      strapPrev_reg <= 7'h00;
      quietCnt_reg <= 3'h0;
    end
    else
    begin
      strapPrev_reg <= straps;
      if (straps != strapPrev_reg)
        quietCnt_reg <= 3'h0;
      else if (quietCnt_reg != 3'h7)
        quietCnt_reg <= quietCnt_reg + 3'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  rsvd_zero_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1c
      |-> wb_dat_o[31:7] == 25'h0) else $error("settings top bits set");
  hr_bit_a:
    assert property (rdSet |-> wb_dat_o[6] == highResolutionSelect)
      else $error("resolution bit wrong");
  osr_field_a:
    assert property (rdSet |-> wb_dat_o[5:4] == oversamplingRatioSelect)
      else $error("ratio field wrong");
  filter_field_a:
    assert property (rdSet |-> wb_dat_o[3:2] == filterSelect)
      else $error("filter field wrong");
  format_bit_a:
    assert property (rdSet |-> wb_dat_o[1] == interfaceFormatSelect)
      else $error("format bit wrong");
  role_bit_a:
    assert property (rdSet |-> wb_dat_o[0] == frameSyncRole)
      else $error("role bit wrong");
  dout_hiz_a:
    assert property ((chipSelectN && !interfaceFormatSelect)[*6]
      |-> !serialDataOe) else $error("data out driven while deselected");
  fs_slave_a:
    assert property ((!frameSyncRole)[*6] |-> !frameSyncOe)
      else $error("frame sync driven as slave");
  ready_pulse_a:
    assert property ($fell(sampleReadyN)
      |-> (!sampleReadyN)[*4] ##1 sampleReadyN)
      else $error("ready pulse width wrong");
  pwdn_quiet_a:
    assert property ((!resetPowerdownN)[*8] |-> sampleReadyN)
      else $error("ready during powerdown");
  fs_pulse_a:
    assert property ($rose(frameSyncOut) |-> frameSyncOe)
      else $error("frame sync pulse without master role");
  cover property (rdSet);
  cover property ($fell(sampleReadyN));
  cover property (serialDataOe && !chipSelectN);
endmodule

bind adm_top adm_top_chk u_adm_top_chk (
  .mclk, .resetn, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .highResolutionSelect, .oversamplingRatioSelect, .filterSelect,
  .interfaceFormatSelect, .frameSyncRole, .resetPowerdownN, .chipSelectN,
  .frameSyncOe, .frameSyncOut, .serialDataOe, .sampleReadyN);

`default_nettype wire

// >>> pkg/adm_consts.vh
`ifndef ADM_CONSTS_VH
`define ADM_CONSTS_VH

// register indexes; byte address is four times the index
`define ADM_IDX_SETTINGS 6'h07
`define ADM_IDX_CONTROL  6'h08
`define ADM_IDX_RATIO    6'h09

// settings register field positions
`define ADM_SET_RSVD     7
`define ADM_SET_HR       6
`define ADM_SET_OSR_HI   5
`define ADM_SET_OSR_LO   4
`define ADM_SET_FLT_HI   3
`define ADM_SET_FLT_LO   2
`define ADM_SET_FORMAT   1
`define ADM_SET_ROLE     0

// control register
`define ADM_CTL_SWD      0
`define ADM_CTL_RESET    1'h0

// filter codes
`define ADM_FLT_LOWLAT   2'h2

// oversampling ratios, wideband filters
`define ADM_WB_R0        12'h020
`define ADM_WB_R1        12'h040
`define ADM_WB_R2        12'h080
`define ADM_WB_R3        12'h100
// oversampling ratios, low-latency filter
`define ADM_LL_R0        12'h020
`define ADM_LL_R1        12'h080
`define ADM_LL_R2        12'h200
`define ADM_LL_R3        12'h800

// frame layout
`define ADM_WORD_BITS    32
`define ADM_DATA_BITS    24
`define ADM_SHORT_POS    8

// timing: period and latency shift amounts, ready strobe in mclk cycles, counter width in bits
`define ADM_MOD_SHIFT    1
`define ADM_LAT_SHIFT    2
`define ADM_SAMPLE_READY_STROBE_CYC     4'h4
`define ADM_CNT_W        16

// link pins at rest: select and power-down high, the rest low
`define ADM_LINK_IDLE    6'h11

`endif
